// ---- logic/tbst_seq.sv ----
// Self-test sequencer: APB registers, buffer memory master, serial test frames
`timescale 1ns/100ps
module tbst_seq import tbst_pkg::*; #(
  parameter logic [7:0] SER_DIV = 8'h04
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Buffer memory master
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic [3:0] mem_fc,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  // Serial symbol interface
  output logic [7:0] tx_sym_data,
  output logic tx_sym_valid,
  output logic tx_sym_last,
  output logic tx_sym_pre,
  input wire logic [7:0] rx_sym_data,
  input wire logic rx_sym_valid,
  input wire logic rx_sym_last,
  input wire logic medium_busy
);
  tbst_state_t state_reg, state_next;
  logic [7:0] cmd_reg, ser_cnt_reg;
  logic [15:0] param0_reg, param1_reg, param2_reg, ptp_reg, hold_reg, hold_cnt_reg;
  logic [2:0] mode_reg;
  logic [1:0] res_reg;
  logic done_reg, detached_state_cmd_reg, tx_queue_empty_flag_reg, err_reg, rx_bad_reg;
  logic pready_reg, pslverr_reg, mem_req_reg, mem_we_reg;
  logic [31:0] prdata_reg, mem_addr_reg, rx_ptr_reg, tx_crc_reg, rx_crc_reg;
  logic [7:0] mem_wdata_reg, itx_data_reg, txo_data_reg;
  logic itx_valid_reg, itx_last_reg, itx_pre_reg, txo_valid_reg, txo_last_reg, txo_pre_reg;
  logic [6:0] idx_reg, tx_pos_reg, rx_cnt_reg, rx_len_reg;
  logic tx_started_reg, tx_stop_reg;
  logic [7:0] arr_mem [ARR_DEPTH];
  logic [7:0] rxa_mem [RX_DEPTH];

  // Register access decode
  wire logic acc = psel & penable & pready_reg;
  wire logic wr = acc & pwrite;
  wire logic setup = psel & ~penable;
  wire logic wr_cmd = wr & (paddr == REG_CMD);
  wire logic wr_stat = wr & (paddr == REG_STATUS);
  wire logic wr_ctrl = wr & (paddr == REG_CTRL);
  wire logic [7:0] wop = pwdata[7:0];
  wire logic new_rx = wop == OP_RX_TEST;
  wire logic new_test = new_rx | (wop == OP_HOST_TEST) | (wop == OP_LOOP_TEST) | ((wop & OP_TX_MASK) == OP_TX_TEST);
  wire logic idle = state_reg == S_IDLE;
  wire logic cmd_accept = wr_cmd & new_test & detached_state_cmd_reg & idle;
  wire logic cmd_reject = wr_cmd & new_test & ~detached_state_cmd_reg & idle;
  wire logic detach = wr_ctrl & pwdata[CTRL_DETACH_BIT];
  wire logic is_host = cmd_reg == OP_HOST_TEST;
  wire logic is_loop = cmd_reg == OP_LOOP_TEST;
  wire logic is_tx = (cmd_reg & OP_TX_MASK) == OP_TX_TEST;
  wire logic is_rx = cmd_reg == OP_RX_TEST;
  wire logic rx_crc_store_enable = mode_reg[MODE_RX_CRC_STORE_ENABLE_BIT];
  wire logic tx_crc_disable = mode_reg[MODE_TX_CRC_DISABLE_BIT];
  wire logic lb_int = mode_reg[MODE_ILB_BIT];
  wire logic [31:0] base = {param1_reg, param2_reg};
  wire logic ser_en = ser_cnt_reg == SER_DIV - 8'h01;
  wire logic addr_hit = (paddr[1:0] == 2'h0) && (paddr <= REG_CTRL);
  logic [31:0] rd_val;
  always_comb begin
    case (paddr)
      REG_CMD: rd_val = {24'h000000, cmd_reg};
      REG_PARAM0: rd_val = {16'h0000, param0_reg};
      REG_PARAM1: rd_val = {16'h0000, param1_reg};
      REG_PARAM2: rd_val = {16'h0000, param2_reg};
      REG_STATUS: rd_val = {28'h0000000, tx_queue_empty_flag_reg, detached_state_cmd_reg, ~idle, done_reg};
      REG_RESULT: rd_val = {30'h00000000, res_reg};
      REG_MODE: rd_val = {29'h00000000, mode_reg};
      REG_PREAMBLE: rd_val = {16'h0000, ptp_reg};
      REG_HOLD: rd_val = {16'h0000, hold_reg};
      default: rd_val = 32'h00000000;
    endcase
  end

  // Fetch and write-back geometry
  wire logic [6:0] fetch_n = is_host ? HOST_BYTES : LOOP_TX_BYTES;
  wire logic [6:0] fetch_ofs = is_loop ? LOOP_FETCH_OFS : 7'h00;
  wire logic [6:0] st_cnt = rx_crc_store_enable ? rx_len_reg :
    ((rx_len_reg >= CRC_BYTES) ? rx_len_reg - CRC_BYTES : 7'h00);
  wire logic [6:0] wr_n = is_host ? HOST_BYTES : st_cnt;
  wire logic [6:0] wr_ofs = is_host ? RET_OFS : LOOP_STORE_OFS;
  wire logic [7:0] ind0 = is_host ? 8'h00 : {1'b0, rx_len_reg};
  wire logic [7:0] ind1 = is_host ? 8'h00 : {rx_bad_reg, 7'h00};
  wire logic [7:0] src_byte = is_host ? arr_mem[idx_reg[5:0]] : rxa_mem[idx_reg[5:0]];
  wire logic [7:0] wr_byte = (idx_reg < wr_n) ? src_byte : ((idx_reg == wr_n) ? ind0 : ind1);
  wire logic mem_done = mem_req_reg & mem_ack;

  // Transmit frame shape
  wire logic [6:0] rx_len_cfg = {2'h0, ptp_reg[15:11]} + FRAME_LEN_ADJ;
  wire logic [6:0] frm_len = is_rx ? ((rx_len_cfg > MAX_FRAME) ? MAX_FRAME : rx_len_cfg) : LOOP_TX_BYTES;
  wire logic crc_on = is_rx | ~tx_crc_disable;
  wire logic [6:0] gap_n = {4'h0, ptp_reg[10:8]} + GAP_ADJ;
  wire logic [6:0] tot_n = gap_n + frm_len + (crc_on ? CRC_BYTES : 7'h00);
  wire logic in_pre = tx_pos_reg < gap_n;
  wire logic in_dat = ~in_pre & (tx_pos_reg < gap_n + frm_len);
  wire logic [6:0] dpos = tx_pos_reg - gap_n;
  wire logic [7:0] pat_byte = dpos[0] ? param0_reg[15:8] : param0_reg[7:0];
  wire logic [7:0] dbyte = is_rx ? pat_byte : arr_mem[dpos[5:0]];
  wire logic [31:0] tx_crc_new = tbst_crc_byte((dpos == 7'h00) ? CRC_INIT : tx_crc_reg, dbyte);
  wire logic tx_end = tx_pos_reg == tot_n - 7'h01;
  wire logic med = lb_int ? 1'b0 : medium_busy;
  wire logic wait_ok = (is_tx & cmd_reg[OP_SILNOI_BIT]) ? med : ~med;
  wire logic tx_go = ser_en & (state_reg == S_SERIAL) & ~tx_stop_reg & (tx_started_reg | ~is_tx | wait_ok);
  wire logic hold_out = is_tx & ~lb_int & (hold_cnt_reg == 16'h0000);

  // Receive path, looped internally when selected
  wire logic rx_v = (state_reg == S_SERIAL) & (lb_int ? itx_valid_reg : rx_sym_valid);
  wire logic [7:0] rx_d = lb_int ? itx_data_reg : rx_sym_data;
  wire logic rx_l = lb_int ? itx_last_reg : rx_sym_last;
  wire logic [31:0] rx_crc_new = tbst_crc_byte((rx_cnt_reg == 7'h00) ? CRC_INIT : rx_crc_reg, rx_d);
  wire logic frame_end = rx_v & rx_l;
  wire logic frame_bad = (rx_crc_new != 32'h00000000) | (rx_cnt_reg + 7'h01 < MIN_FRAME);
  wire logic rx_store = rx_v & is_rx & ~mem_req_reg;
  wire logic mem_issue = ~mem_req_reg & ((state_reg == S_FETCH) | (state_reg == S_WRITE) | rx_store);
  wire logic [31:0] mem_ofs = (state_reg == S_FETCH) ? 32'(fetch_ofs + idx_reg) :
    (state_reg == S_WRITE) ? 32'(wr_ofs + idx_reg) : rx_ptr_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: if (cmd_accept) state_next = new_rx ? S_SERIAL : S_FETCH;
      S_FETCH: if (mem_done && idx_reg == fetch_n - 7'h01) state_next = is_host ? S_WRITE : S_SERIAL;
      S_SERIAL: begin
        if (is_loop && frame_end) state_next = S_WRITE;
        else if (!is_loop && detach) state_next = S_DONE;
      end
      S_WRITE: if (mem_done && idx_reg == wr_n + 7'h01) state_next = S_DONE;
      S_DONE: state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  // APB slave: zero-wait, read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~addr_hit;
      prdata_reg <= setup ? rd_val : 32'h00000000;
    end
  end

  // Software-visible registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg <= 8'h00;
      param0_reg <= 16'h0000;
      param1_reg <= 16'h0000;
      param2_reg <= 16'h0000;
      mode_reg <= 3'h0;
      ptp_reg <= PREAMBLE_RST;
      hold_reg <= HOLD_RST;
      done_reg <= 1'b0;
      detached_state_cmd_reg <= 1'b1;
      res_reg <= 2'h0;
    end else begin
      if (cmd_accept) cmd_reg <= wop;
      if (wr && paddr == REG_PARAM0) param0_reg <= pwdata[15:0];
      if (wr && paddr == REG_PARAM1) param1_reg <= pwdata[15:0];
      if (wr && paddr == REG_PARAM2) param2_reg <= pwdata[15:0];
      if (wr && paddr == REG_MODE && idle) mode_reg <= pwdata[2:0];
      if (wr && paddr == REG_PREAMBLE && idle) ptp_reg <= pwdata[15:0];
      if (wr && paddr == REG_HOLD && idle) hold_reg <= pwdata[15:0];
      // Completion set beats a clear in the same cycle
      done_reg <= (state_reg == S_DONE) | cmd_reject |
        (done_reg & ~(wr_stat & pwdata[ST_DONE_BIT]) & ~cmd_accept);
      if (detach) detached_state_cmd_reg <= 1'b1;
      else if (wr_ctrl && pwdata[CTRL_ONLINE_BIT] && idle) detached_state_cmd_reg <= 1'b0;
      if (cmd_accept) res_reg <= 2'h0;
      else if (cmd_reject) res_reg <= 2'h1;
      else if (state_reg == S_SERIAL && state_next == S_DONE) res_reg[RES_ERR_BIT] <= err_reg;
    end
  end

  // Sequencer state, buffer memory master
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      idx_reg <= 7'h00;
      rx_ptr_reg <= 32'h00000000;
      mem_req_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= 32'h00000000;
      mem_wdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (cmd_accept || (mem_done && state_next != state_reg)) idx_reg <= 7'h00;
      else if (mem_done && state_reg != S_SERIAL) idx_reg <= idx_reg + 7'h01;
      if (cmd_accept) rx_ptr_reg <= 32'h00000000;
      else if (rx_store) rx_ptr_reg <= rx_ptr_reg + 32'h00000001;
      if (mem_done) mem_req_reg <= 1'b0;
      else if (mem_issue) begin
        mem_req_reg <= 1'b1;
        mem_we_reg <= state_reg != S_FETCH;
        mem_addr_reg <= base + mem_ofs;
        mem_wdata_reg <= (state_reg == S_SERIAL) ? rx_d : wr_byte;
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (mem_done && state_reg == S_FETCH) arr_mem[idx_reg[5:0]] <= mem_rdata;
    if (rx_v && is_loop && rx_cnt_reg < 7'(RX_DEPTH)) rxa_mem[rx_cnt_reg[5:0]] <= rx_d;
  end

  // Transmit machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_cnt_reg <= 8'h00;
      tx_pos_reg <= 7'h00;
      tx_crc_reg <= 32'h00000000;
      tx_started_reg <= 1'b0;
      tx_stop_reg <= 1'b0;
      hold_cnt_reg <= 16'h0000;
      tx_queue_empty_flag_reg <= 1'b0;
      itx_data_reg <= 8'h00;
      itx_valid_reg <= 1'b0;
      itx_last_reg <= 1'b0;
      itx_pre_reg <= 1'b0;
    end else begin
      ser_cnt_reg <= ser_en ? 8'h00 : ser_cnt_reg + 8'h01;
      itx_valid_reg <= tx_go & ~in_pre;
      itx_pre_reg <= tx_go & in_pre;
      itx_last_reg <= tx_go & tx_end;
      if (cmd_accept) begin
        tx_pos_reg <= 7'h00;
        tx_started_reg <= 1'b0;
        tx_stop_reg <= 1'b0;
        hold_cnt_reg <= hold_reg;
        tx_queue_empty_flag_reg <= 1'b0;
      end else if (tx_go) begin
        tx_started_reg <= 1'b1;
        itx_data_reg <= in_pre ? ptp_reg[7:0] : (in_dat ? dbyte : tx_crc_reg[7:0]);
        if (in_dat) tx_crc_reg <= tx_crc_new;
        else if (!in_pre) tx_crc_reg <= tx_crc_reg >> 8;
        tx_pos_reg <= tx_end ? 7'h00 : tx_pos_reg + 7'h01;
        if (tx_end && is_loop) tx_stop_reg <= 1'b1;
        if (hold_out) begin
          tx_stop_reg <= 1'b1;
          tx_queue_empty_flag_reg <= 1'b1;
        end else if (is_tx && !lb_int) hold_cnt_reg <= hold_cnt_reg - 16'h0001;
      end
    end
  end

  // Receive checker and external pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cnt_reg <= 7'h00;
      rx_crc_reg <= 32'h00000000;
      rx_len_reg <= 7'h00;
      rx_bad_reg <= 1'b0;
      err_reg <= 1'b0;
      txo_data_reg <= 8'h00;
      txo_valid_reg <= 1'b0;
      txo_last_reg <= 1'b0;
      txo_pre_reg <= 1'b0;
    end else begin
      txo_valid_reg <= itx_valid_reg & ~lb_int;
      txo_last_reg <= itx_last_reg & ~lb_int;
      txo_pre_reg <= itx_pre_reg & ~lb_int;
      txo_data_reg <= lb_int ? 8'h00 : itx_data_reg;
      if (cmd_accept) begin
        rx_cnt_reg <= 7'h00;
        err_reg <= 1'b0;
      end else if (rx_v) begin
        rx_crc_reg <= rx_crc_new;
        rx_cnt_reg <= rx_l ? 7'h00 : rx_cnt_reg + 7'h01;
        if (frame_end) begin
          rx_len_reg <= rx_cnt_reg + 7'h01;
          rx_bad_reg <= rx_crc_new != 32'h00000000;
          if (is_tx && frame_bad) err_reg <= 1'b1;
        end
        if (is_rx && mem_req_reg) err_reg <= 1'b1;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign mem_req = mem_req_reg;
  assign mem_we = mem_we_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign mem_fc = param0_reg[3:0];
  assign tx_sym_data = txo_data_reg;
  assign tx_sym_valid = txo_valid_reg;
  assign tx_sym_last = txo_last_reg;
  assign tx_sym_pre = txo_pre_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_test_start;
    idle ##1 !idle;
  endsequence
  sequence s_host_ret;
    state_reg == S_WRITE && is_host && mem_req_reg && idx_reg < HOST_BYTES;
  endsequence
  a_start_when_detached: assert property (s_test_start |-> $past(detached_state_cmd_reg, 1))
    else $error("test started while online");
  a_done_quiet_run: assert property (!idle && state_reg != S_DONE |-> !done_reg)
    else $error("done set while test running");
  a_done_cause: assert property ($rose(done_reg) |-> $past(state_reg) == S_DONE || $past(cmd_reject))
    else $error("done set without completion");
  a_host_copy_addr: assert property (s_host_ret |-> mem_addr_reg == base + RET_OFS + idx_reg)
    else $error("host test write-back address wrong");
  a_host_ind_zero: assert property (state_reg == S_WRITE && is_host && mem_req_reg && idx_reg >= HOST_BYTES
    |-> mem_wdata_reg == 8'h00)
    else $error("host test indication not zero");
  a_loop_skip_first: assert property (state_reg == S_FETCH && is_loop && mem_req_reg |-> mem_addr_reg != base)
    else $error("loopback fetched byte 0");
  a_loop_skip_ret0: assert property (state_reg == S_WRITE && is_loop && mem_req_reg
    |-> mem_addr_reg != base + RET_OFS)
    else $error("loopback wrote return byte 0");
  a_loop_len_ind: assert property (state_reg == S_WRITE && is_loop && mem_req_reg && idx_reg == st_cnt
    |-> mem_wdata_reg == {1'b0, rx_len_reg} && mem_addr_reg == base + LOOP_STORE_OFS + st_cnt)
    else $error("loopback length indication wrong");
  a_loop_crc_flag: assert property (state_reg == S_WRITE && is_loop && mem_req_reg && idx_reg == st_cnt + 7'h01
    |-> mem_wdata_reg[7] == rx_bad_reg)
    else $error("loopback error flag wrong");
  a_pins_silent: assert property (tx_sym_valid |-> !$past(lb_int, 1))
    else $error("external pins active in internal loopback");
  a_txtest_no_store: assert property (state_reg == S_SERIAL && is_tx |-> !mem_req_reg)
    else $error("transmitter test stored frame data");
  a_detach_ends: assert property (state_reg == S_SERIAL && !is_loop && detach |=> state_reg == S_DONE ##1 done_reg)
    else $error("detach did not end test");
endmodule : tbst_seq

// ---- logic/tbst_pkg.sv ----
// Constants, types and CRC helper for the token bus self-test sequencer
package tbst_pkg;
  // Test opcodes
  localparam logic [7:0] OP_RX_TEST = 8'hB0;
  localparam logic [7:0] OP_TX_TEST = 8'hB4;
  localparam logic [7:0] OP_TX_MASK = 8'hFD;
  localparam logic [7:0] OP_LOOP_TEST = 8'hB8;
  localparam logic [7:0] OP_HOST_TEST = 8'hBC;
  localparam int OP_SILNOI_BIT = 1;
  // Buffer layout, byte offsets from the buffer pointer
  localparam logic [6:0] HOST_BYTES = 7'h22;
  localparam logic [6:0] LOOP_TX_BYTES = 7'h21;
  localparam logic [6:0] RET_OFS = 7'h22;
  localparam logic [6:0] LOOP_STORE_OFS = 7'h23;
  localparam logic [6:0] LOOP_FETCH_OFS = 7'h01;
  localparam logic [6:0] CRC_BYTES = 7'h04;
  localparam logic [6:0] MAX_FRAME = 7'h21;
  localparam logic [6:0] MIN_FRAME = 7'h05;
  localparam logic [6:0] FRAME_LEN_ADJ = 7'h02;
  localparam logic [6:0] GAP_ADJ = 7'h01;
  localparam int ARR_DEPTH = 34;
  localparam int RX_DEPTH = 40;
  // Register byte offsets
  localparam logic [11:0] REG_CMD = 12'h000;
  localparam logic [11:0] REG_PARAM0 = 12'h004;
  localparam logic [11:0] REG_PARAM1 = 12'h008;
  localparam logic [11:0] REG_PARAM2 = 12'h00C;
  localparam logic [11:0] REG_STATUS = 12'h010;
  localparam logic [11:0] REG_RESULT = 12'h014;
  localparam logic [11:0] REG_MODE = 12'h018;
  localparam logic [11:0] REG_PREAMBLE = 12'h01C;
  localparam logic [11:0] REG_HOLD = 12'h020;
  localparam logic [11:0] REG_CTRL = 12'h024;
  // Field positions
  localparam int ST_DONE_BIT = 0;
  localparam int CTRL_DETACH_BIT = 0;
  localparam int CTRL_ONLINE_BIT = 1;
  localparam int MODE_RX_CRC_STORE_ENABLE_BIT = 0;
  localparam int MODE_TX_CRC_DISABLE_BIT = 1;
  localparam int MODE_ILB_BIT = 2;
  localparam int RES_ERR_BIT = 1;
  // Reset values
  localparam logic [15:0] PREAMBLE_RST = 16'h00AA;
  localparam logic [15:0] HOLD_RST = 16'hFFFF;
  // CRC-32, reflected, no final inversion: a good frame leaves zero
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_FETCH = 3'b001,
    S_SERIAL = 3'b010,
    S_WRITE = 3'b011,
    S_DONE = 3'b100
  } tbst_state_t;

  function automatic logic [31:0] tbst_crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : tbst_crc_byte
endpackage : tbst_pkg

// ---- tb/tbst_mem.sv ----
// Buffer memory on the system bus, answering byte requests after a set delay
`timescale 1ns/100ps
module tbst_mem (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Byte requests from the sequencer
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_ack,
  // Wait cycles before each answer
  input wire logic [3:0] delay
);
  logic [7:0] mem [0:255];
  logic [3:0] wait_cnt;
  int n_wr;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 8'h00;
      n_wr <= 0;
    end else begin
      mem_ack <= 1'b0;
      // Read data is only good with the answer; otherwise it keeps changing
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        if (wait_cnt == delay) begin
          wait_cnt <= 4'h0;
          mem_ack <= 1'b1;
          if (mem_we) begin
            mem[mem_addr[7:0]] <= mem_wdata;
            n_wr <= n_wr + 1;
          end else begin
            mem_rdata <= mem[mem_addr[7:0]];
          end
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
endmodule : tbst_mem

// ---- tb/token_bus_self_test_bench.sv ----
// Testbench for the token bus self-test sequencer
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module token_bus_self_test_bench import tbst_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic medium_busy = 1'b0, corrupt = 1'b0, pready, pslverr, serr;
  logic mem_req, mem_we, mem_ack, tx_sym_valid, tx_sym_last, tx_sym_pre;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, mem_addr;
  logic [7:0] mem_wdata, mem_rdata, tx_sym_data;
  logic [3:0] mem_fc, mem_dly = 4'h0;
  int failures = 0, n_tests = 0, tx_cnt = 0, pre_cnt = 0, lst_cnt = 0, n, w0;
  // External loopback wire; a released line shows the inverse
  wire logic [7:0] rx_d = tx_sym_valid ? (tx_sym_data ^ {7'h00, corrupt}) : ~tx_sym_data;
  tbst_seq #(.SER_DIV(8'h04)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_fc, .mem_rdata, .mem_ack,
    .tx_sym_data, .tx_sym_valid, .tx_sym_last, .tx_sym_pre, .rx_sym_data(rx_d),
    .rx_sym_valid(tx_sym_valid), .rx_sym_last(tx_sym_last), .medium_busy);
  tbst_mem MEM (.pclk, .presetn, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
    .delay(mem_dly));
  always #2 pclk = ~pclk;
  // Counts data bytes, preamble octets and frame ends on the external pins
  always @(posedge pclk) begin
    if (tx_sym_valid === 1'b1) tx_cnt++;
    if (tx_sym_pre === 1'b1) pre_cnt++;
    if (tx_sym_last === 1'b1) lst_cnt++;
  end
  task automatic stop_test;
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rd = prdata;
    serr = pslverr;
    `CHK("pready", 1'b1, pready)
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic run_cmd(input logic [7:0] op);
    apb(1'b1, REG_STATUS, 32'h0000_0001);
    apb(1'b1, REG_CMD, {24'h000000, op});
  endtask : run_cmd
  task automatic wait_st(input int b);
    int i;
    i = 0;
    rd = 32'h0000_0000;
    while (rd[b] !== 1'b1 && i < 3000) begin
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      i++;
    end
    `CHK("status bit", 1'b1, rd[b])
  endtask : wait_st
  initial begin
    #300000;
    failures++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_STATUS, 32'h0); `CHK("status", 32'h0000_0004, rd)
    apb(1'b0, REG_PREAMBLE, 32'h0); `CHK("preamble", {16'h0000, PREAMBLE_RST}, rd)
    apb(1'b0, REG_HOLD, 32'h0); `CHK("hold", {16'h0000, HOLD_RST}, rd)
    apb(1'b1, 12'h028, 32'h1); `CHK("slverr", 1'b1, serr)
    apb(1'b0, 12'h028, 32'h0); `CHK("unmapped", 32'h0000_0000, rd)
    apb(1'b1, REG_PARAM0, 32'h3);
    apb(1'b1, REG_PARAM1, 32'h0);
    apb(1'b1, REG_PARAM2, 32'h1000);
    `CHK("fc", 4'h3, mem_fc)
    for (int i = 0; i < 34; i++) MEM.mem[i] = 8'h30 + 8'(i);
    // Host interface copy with a slow memory
    mem_dly <= 4'h3;
    run_cmd(OP_HOST_TEST);
    apb(1'b0, REG_STATUS, 32'h0); `CHK("busy", 2'b10, rd[1:0])
    wait_st(ST_DONE_BIT);
    for (int i = 0; i < 34; i++) `CHK("copy", 8'h30 + 8'(i), MEM.mem[34 + i])
    `CHK("indic", 16'h0000, {MEM.mem[68], MEM.mem[69]})
    // Loopback over all CRC store / disable settings, internal path
    mem_dly <= 4'h0;
    for (int m = 0; m < 4; m++) begin
      n = 33 + (m[0] ? 4 : 0) - (m[1] ? 4 : 0);
      apb(1'b1, REG_MODE, {29'h0, 1'b1, m[1:0]});
      tx_cnt = 0;
      run_cmd(OP_LOOP_TEST);
      wait_st(ST_DONE_BIT);
      `CHK("tx pins", 0, tx_cnt)
      `CHK("ret0", 8'h30, MEM.mem[34])
      for (int k = 0; k < n && k < 33; k++) `CHK("loop", 8'h31 + 8'(k), MEM.mem[35 + k])
      if (!m[1]) `CHK("ind0", 8'h25, MEM.mem[35 + n])
      if (!m[1]) `CHK("ind1", 8'h00, MEM.mem[36 + n])
    end
    // External loopback with corrupted receive data
    apb(1'b1, REG_MODE, 32'h0);
    corrupt <= 1'b1;
    run_cmd(OP_LOOP_TEST);
    wait_st(ST_DONE_BIT);
    `CHK("crc err", 1'b1, MEM.mem[69][7])
    // Transmitter test waiting for noise, errors reported at detach
    apb(1'b1, REG_HOLD, 32'hFFFF);
    w0 = MEM.n_wr;
    tx_cnt = 0;
    run_cmd(OP_TX_TEST | 8'h02);
    repeat (300) @(posedge pclk);
    `CHK("noise wait", 0, tx_cnt)
    medium_busy <= 1'b1;
    repeat (300) @(posedge pclk);
    `CHK("noise go", 1'b1, tx_cnt > 0)
    apb(1'b1, REG_CTRL, 32'h1);
    wait_st(ST_DONE_BIT);
    `CHK("no store", w0, MEM.n_wr)
    apb(1'b0, REG_RESULT, 32'h0); `CHK("tx err", 1'b1, rd[1])
    // Transmitter test on silence, bounded by hold time
    corrupt <= 1'b0;
    medium_busy <= 1'b0;
    apb(1'b1, REG_HOLD, 32'h40);
    tx_cnt = 0;
    pre_cnt = 0;
    lst_cnt = 0;
    run_cmd(OP_TX_TEST);
    wait_st(3);
    `CHK("silence go", 1'b1, tx_cnt > 0)
    apb(1'b1, REG_CTRL, 32'h1);
    wait_st(ST_DONE_BIT);
    apb(1'b0, REG_RESULT, 32'h0); `CHK("tx ok", 1'b0, rd[1])
    // Hold of 40h slots: 65 slots, two frame starts, one whole frame
    `CHK("hold slots", 63, tx_cnt)
    `CHK("preambles", 2, pre_cnt)
    `CHK("frame ends", 1, lst_cnt)
    // Internal loopback transmitter test on silence, noise outside is ignored
    apb(1'b1, REG_MODE, 32'h4);
    medium_busy <= 1'b1;
    tx_cnt = 0;
    run_cmd(OP_TX_TEST);
    repeat (600) @(posedge pclk);
    apb(1'b0, REG_STATUS, 32'h0); `CHK("no bound", 1'b0, rd[3])
    apb(1'b1, REG_CTRL, 32'h1);
    wait_st(ST_DONE_BIT);
    `CHK("int pins", 0, tx_cnt)
    apb(1'b0, REG_RESULT, 32'h0); `CHK("int ok", 1'b0, rd[1])
    medium_busy <= 1'b0;
    // Receiver test, five byte frames of the pattern word
    apb(1'b1, REG_MODE, 32'h4);
    apb(1'b1, REG_PREAMBLE, 32'h1BAA);
    apb(1'b1, REG_PARAM0, 32'h5A5A);
    run_cmd(OP_RX_TEST);
    repeat (200) @(posedge pclk);
    apb(1'b1, REG_CTRL, 32'h1);
    wait_st(ST_DONE_BIT);
    for (int k = 0; k < 4; k++) `CHK("rx pattern", 8'h5A, MEM.mem[k])
    // Test command refused while online
    apb(1'b1, REG_CTRL, 32'h2);
    run_cmd(OP_HOST_TEST);
    wait_st(ST_DONE_BIT);
    apb(1'b0, REG_RESULT, 32'h0); `CHK("reject", 1'b1, rd[0])
    stop_test();
  end
endmodule : token_bus_self_test_bench
